// *** src/ats_adc_timing_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - the basic clock is the cpu clock divided by 4, 2, 16 or 8 for select codes 00, 01, 10, 11.
// - the sample phase lasts 8, 16, 32 or 64 basic clock periods for sample codes 00 to 11.
// - a conversion lasts the sample time plus 40 basic periods plus 2 cpu periods, load included.
// - sample time and basic clock are set by the two select fields; a low clock enable freezes the sequencer and stretches both.
// - after reset a calibration of 3328 basic clock periods runs.
// - conversions requested during calibration still run and push calibration completion back.
// - input below ground gives all zeros, above reference all ones, in the ten result bits.
// - the value is held once sampling ends, later input changes do not matter.
module ats_adc_timing_sequencer
    import ats_pkg::*;
#(
    parameter int CAL_PERIODS = 3328
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // control
    input wire logic [CTRL_W-1:0] converter_control_word_i,
    input wire logic start_i,
    // analog front end
    input wire logic [RES_W-1:0] ain_code_i,
    input wire logic ain_below_gnd_i,
    input wire logic ain_above_ref_i,
    // status and result
    output logic busy_o,
    output logic done_o,
    output logic sample_o,
    output logic cal_busy_o,
    output logic [RES_W-1:0] result_o
);
    // ------------------------------------------------------------
    // select decoding
    // ------------------------------------------------------------
    logic [1:0] conv_clock_select;
    logic [1:0] sample_time_select;
    logic [4:0] div_sel;
    logic [11:0] smp_sel;
    assign conv_clock_select = converter_control_word_i[CLK_SEL_HI:CLK_SEL_LO];
    assign sample_time_select = converter_control_word_i[SMP_SEL_HI:SMP_SEL_LO];
    always_comb begin
        case (conv_clock_select)
            CLK_DIV4: div_sel = DIV_BY_4;
            CLK_DIV2: div_sel = DIV_BY_2;
            CLK_DIV16: div_sel = DIV_BY_16;
            default: div_sel = DIV_BY_8;
        endcase
        case (sample_time_select)
            SMP_8: smp_sel = SMP_P8;
            SMP_16: smp_sel = SMP_P16;
            SMP_32: smp_sel = SMP_P32;
            default: smp_sel = SMP_P64;
        endcase
    end
    // ------------------------------------------------------------
    // basic clock tick generator
    // ------------------------------------------------------------
    logic [4:0] div_reg;
    logic [4:0] div_use;
    logic bc_tick;
    ats_state_t state_reg;
    logic [4:0] div_lock_reg;
    // the divide is latched while a conversion runs so a select change cannot stretch it
    assign div_use = (state_reg == ST_IDLE) ? div_sel : div_lock_reg;
    assign bc_tick = (div_reg == div_use - 5'h01);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 5'h00;
        end else if (ce_i) begin
            if (bc_tick || div_reg >= div_use) begin
                div_reg <= 5'h00;
            end else begin
                div_reg <= div_reg + 5'h01;
            end
        end
    end
    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    logic [11:0] cnt_reg;
    logic [RES_W-1:0] held_reg;
    logic [11:0] smp_lock_reg;
    logic take_now;
    logic smp_last;
    logic conv_last;
    logic load_now;
    assign take_now = (state_reg == ST_IDLE) && start_i && bc_tick;
    assign smp_last = (state_reg == ST_SAMPLE) && bc_tick
        && (cnt_reg == smp_lock_reg - 12'h001);
    assign conv_last = (state_reg == ST_CONVERT) && bc_tick
        && (cnt_reg == CONV_BC_PERIODS - 12'h001);
    assign load_now = (state_reg == ST_LOAD)
        && (cnt_reg == {10'h000, LOAD_CPU_PERIODS} - 12'h001);
    // state walk
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else if (ce_i) begin
            case (state_reg)
                ST_IDLE: begin
                    if (take_now) begin
                        state_reg <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (smp_last) begin
                        state_reg <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (conv_last) begin
                        state_reg <= ST_LOAD;
                    end
                end
                default: begin
                    if (load_now) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // period counter: basic ticks in sample and convert, cpu cycles in load
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 12'h000;
        end else if (ce_i) begin
            if (take_now || smp_last || conv_last || load_now) begin
                cnt_reg <= 12'h000;
            end else if (state_reg == ST_LOAD || (state_reg != ST_IDLE && bc_tick)) begin
                cnt_reg <= cnt_reg + 12'h001;
            end
        end
    end
    // ------------------------------------------------------------
    // select latch, taken with the start
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_lock_reg <= DIV_BY_4;
            smp_lock_reg <= SMP_P8;
        end else if (ce_i && take_now) begin
            div_lock_reg <= div_sel;
            smp_lock_reg <= smp_sel;
        end
    end
    // ------------------------------------------------------------
    // sample and hold, frozen at the end of the sample phase
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            held_reg <= RES_ZERO;
        end else if (ce_i && smp_last) begin
            if (ain_below_gnd_i) begin
                held_reg <= RES_ZERO;
            end else if (ain_above_ref_i) begin
                held_reg <= RES_FULL;
            end else begin
                held_reg <= ain_code_i;
            end
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // busy drops in the cycle that done rises
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
        end else if (ce_i) begin
            busy_o <= (state_reg != ST_IDLE && !load_now) || take_now;
        end
    end
    // sample falls on the tick that ends the sample phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_o <= 1'b0;
        end else if (ce_i) begin
            sample_o <= (state_reg == ST_SAMPLE && !smp_last) || take_now;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= load_now;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_o <= RES_ZERO;
        end else if (ce_i && load_now) begin
            result_o <= held_reg;
        end
    end
    // ------------------------------------------------------------
    // reset calibration
    // ------------------------------------------------------------
    // only idle basic ticks count, so conversions push the end back
    logic [11:0] cal_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_reg <= 12'h000;
            cal_busy_o <= 1'b1;
        end else if (ce_i && cal_busy_o) begin
            if (bc_tick && state_reg == ST_IDLE && !start_i) begin
                if (cal_reg == 12'(CAL_PERIODS - 1)) begin
                    cal_busy_o <= 1'b0;
                end else begin
                    cal_reg <= cal_reg + 12'h001;
                end
            end
        end
    end
endmodule // ats_adc_timing_sequencer
`default_nettype wire

// *** src/ats_pkg.sv ***
`default_nettype none
package ats_pkg;
    // ------------------------------------------------------------
    // select field positions in the control word
    // ------------------------------------------------------------
    localparam int CTRL_W = 16;
    localparam int CLK_SEL_HI = 15;
    localparam int CLK_SEL_LO = 14;
    localparam int SMP_SEL_HI = 13;
    localparam int SMP_SEL_LO = 12;
    // ------------------------------------------------------------
    // timing constants
    // ------------------------------------------------------------
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV16 = 2'h2;
    localparam logic [1:0] CLK_DIV8 = 2'h3;
    localparam logic [4:0] DIV_BY_2 = 5'h02;
    localparam logic [4:0] DIV_BY_4 = 5'h04;
    localparam logic [4:0] DIV_BY_8 = 5'h08;
    localparam logic [4:0] DIV_BY_16 = 5'h10;
    localparam logic [1:0] SMP_8 = 2'h0;
    localparam logic [1:0] SMP_16 = 2'h1;
    localparam logic [1:0] SMP_32 = 2'h2;
    localparam logic [11:0] SMP_P8 = 12'h008;
    localparam logic [11:0] SMP_P16 = 12'h010;
    localparam logic [11:0] SMP_P32 = 12'h020;
    localparam logic [11:0] SMP_P64 = 12'h040;
    localparam logic [11:0] CONV_BC_PERIODS = 12'h028;
    localparam logic [1:0] LOAD_CPU_PERIODS = 2'h2;
    localparam logic [11:0] CAL_BC_PERIODS = 12'hD00;
    localparam int RES_W = 10;
    localparam logic [9:0] RES_ZERO = 10'h000;
    localparam logic [9:0] RES_FULL = 10'h3FF;
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10,
        ST_LOAD = 2'b11
    } ats_state_t;
endpackage
`default_nettype wire

// *** test/ats_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module ats_checker
    import ats_pkg::*;
#(
    parameter int CAL_PERIODS = 3328
) (
    // clock, reset and control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [CTRL_W-1:0] converter_control_word_i,
    // status and result
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic sample_o,
    input wire logic cal_busy_o,
    input wire logic [RES_W-1:0] result_o
);
    logic [11:0] busy_cnt_reg;
    logic [11:0] smp_cnt_reg;
    logic [CTRL_W-1:0] word_reg;
    logic [4:0] div;
    logic [11:0] smp_len;
    // selects count as taken at the start of a conversion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_reg <= {CTRL_W{1'b0}};
        end else if (!busy_o) begin
            word_reg <= converter_control_word_i;
        end
    end
    assign div = word_reg[CLK_SEL_HI]
        ? (word_reg[CLK_SEL_LO] ? DIV_BY_8 : DIV_BY_16)
        : (word_reg[CLK_SEL_LO] ? DIV_BY_2 : DIV_BY_4);
    assign smp_len = (SMP_P8 << word_reg[SMP_SEL_HI:SMP_SEL_LO]) * div;
    // counts cycles of busy and sample while the clock enable runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_cnt_reg <= 12'h000;
            smp_cnt_reg <= 12'h000;
        end else if (ce_i) begin
            busy_cnt_reg <= busy_o ? busy_cnt_reg + 12'h001 : 12'h000;
            smp_cnt_reg <= sample_o ? smp_cnt_reg + 12'h001 : 12'h000;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_finish;
        !busy_o ##0 $past(busy_o);
    endsequence
    a_done_ends_busy: assert property (done_o |-> s_finish) else $error("done without busy end");
    a_launch_sample: assert property ($rose(busy_o) |-> sample_o) else $error("no sample at launch");
    a_sample_in_busy: assert property (sample_o |-> busy_o) else $error("sample outside busy");
    a_sample_len: assert property ($fell(sample_o) |-> smp_cnt_reg == smp_len)
        else $error("sample length wrong");
    a_conv_len: assert property (done_o |-> busy_cnt_reg == smp_len + CONV_BC_PERIODS * div
        + LOAD_CPU_PERIODS)
        else $error("conversion length wrong");
    a_done_pulse: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
    a_result_hold: assert property (!done_o |-> $stable(result_o)) else $error("result moved");
    a_cal_once: assert property (!cal_busy_o |=> !cal_busy_o) else $error("calibration restarted");
    a_cal_extends: assert property (cal_busy_o && busy_o |=> cal_busy_o) else $error("cal ended");
    a_freeze_holds: assert property (!ce_i |=> $stable(busy_o) && $stable(sample_o)
        && $stable(result_o)) else $error("outputs moved while frozen");
endmodule // ats_checker
bind ats_adc_timing_sequencer ats_checker #(.CAL_PERIODS(CAL_PERIODS)) ats_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .converter_control_word_i(converter_control_word_i),
    .busy_o(busy_o), .done_o(done_o), .sample_o(sample_o), .cal_busy_o(cal_busy_o),
    .result_o(result_o));
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ats_pkg::*;
    localparam int CAL_P = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_i = 1'b0;
    logic ce = 1'b1;
    logic below = 1'b0;
    logic above = 1'b0;
    logic [CTRL_W-1:0] word = 16'h0000;
    logic [RES_W-1:0] code = 10'h000;
    logic busy_o, done_o, sample_o, cal_busy_o;
    logic [RES_W-1:0] result_o;
    int n_errors = 0;
    int n_checks = 0;
    always #5 clk_i = ~clk_i;
    ats_adc_timing_sequencer #(.CAL_PERIODS(CAL_P)) ats_adc_timing_sequencer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .converter_control_word_i(word),
        .start_i(start_i), .ain_code_i(code), .ain_below_gnd_i(below), .ain_above_ref_i(above),
        .busy_o(busy_o), .done_o(done_o), .sample_o(sample_o), .cal_busy_o(cal_busy_o),
        .result_o(result_o));
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        rst_i = 1'b1;
        repeat (20) tick();
        rst_i = 1'b0;
    endtask
    // one conversion; the select word moves once taken, the code and above-reference inputs once sampling is over,
    // and the clock enable drops for fz cycles early in the conversion
    task automatic convert(input logic [3:0] sel, input logic [9:0] c, input logic lo,
        input logic hi, input int fz);
        int n;
        int d;
        d = (sel[3:2] == 2'h0) ? 4 : (sel[3:2] == 2'h1) ? 2 : (sel[3:2] == 2'h2) ? 16 : 8;
        word = {sel, 12'h000};
        code = c;
        below = lo;
        above = hi;
        start_i = 1'b1;
        for (n = 0; n < 40 && busy_o !== 1'b1; n++) tick();
        start_i = 1'b0;
        word = ~word;
        check(sample_o, 1'b1);
        for (n = 0; n < 2000 && done_o !== 1'b1; n++) begin
            ce = !(n >= 20 && n < 20 + fz);
            tick();
            if (sample_o !== 1'b1) begin
                code = ~c;
                above = ~hi;
            end
        end
        ce = 1'b1;
        word = {sel, 12'h000};
        check(n, (8 << sel[1:0]) * d + 40 * d + 2 + fz);
        check(result_o, lo ? 10'h000 : hi ? 10'h3FF : c);
        check(busy_o, 1'b0);
        tick();
        check(done_o, 1'b0);
    endtask
    task automatic cal_runs(input logic with_conv);
        int n;
        do_reset();
        check(cal_busy_o, 1'b1);
        // divide by 16 keeps the basic clock at 6.25 MHz for this cpu clock
        if (with_conv) convert(4'h8, 10'h155, 1'b0, 1'b0, 0);
        if (with_conv) check(cal_busy_o, 1'b1);
        for (n = 0; n < 400 && cal_busy_o !== 1'b0; n++) tick();
        check(n <= CAL_P * 16 + 16, 1'b1);
    endtask
    task automatic sweep();
        // faster divides run the basic clock above its range here; timing and the held result are both judged
        for (int i = 0; i < 16; i++) convert(4'(i), 10'(i * 37), 1'b0, 1'b0, 0);
        convert(4'h0, 10'h2C3, 1'b0, 1'b0, 7);
        convert(4'h1, 10'h0AA, 1'b1, 1'b0, 0);
        convert(4'h1, 10'h0AA, 1'b0, 1'b1, 0);
        convert(4'h1, 10'h0AA, 1'b1, 1'b1, 0);
    endtask
    initial begin
        cal_runs(1'b1);
        cal_runs(1'b0);
        sweep();
        wrap_up();
    end
    // whole run needs about 10000 cycles
    initial begin
        #300000;
        n_errors++;
        wrap_up();
    end
endmodule // tb
`default_nettype wire
